// *** hdl/opp_device.sv ***
/*
 Device end: programming memory, address counter and pin decode.
 Assumes opp_if joined to a programmer; all pins are asynchronous to clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
`include "opp_map.svh"
module opp_device
	import opp_pkg::*;
#(
	parameter int ADDR_W = `OPP_ADDR_W,
	parameter int DEPTH = `OPP_MEM_DEPTH
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	opp_if.dev link,
	input wire logic eprom_mode_i,
	input wire logic osc_drive_i,
	output logic osc_out_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic driving_o,
	output logic wr_pulse_o,
	output logic [`OPP_DATA_W-1:0] last_wr_o,
	output logic [15:0] wr_count_o,
	output logic reject_o,
	output logic wrap_o
);
	localparam int SYNC_W = 16;

	// Sizes the counter can serve
	generate
		if (DEPTH < 2 || DEPTH > (1 << ADDR_W)) begin : g_chk
			$error("opp_device: DEPTH does not fit ADDR_W");
		end
		if (ADDR_W < 1 || ADDR_W > 16) begin : g_chk_aw
			$error("opp_device: ADDR_W out of range");
		end
	endgenerate

	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic aclk_prev_r;
	logic stb_prev_r;
	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] addr_nxt;
	logic [`OPP_DATA_W-1:0] dout_r;
	logic drive_r;
	logic wr_pulse_r;
	logic [`OPP_DATA_W-1:0] last_wr_r;
	logic [15:0] wr_count_r;
	logic reject_r;
	logic wrap_r;
	opp_byte_t mem [DEPTH];

	// Pins regrouped as the programming functions
	assign pin_raw = {
		link.prog_data_bus,
		link.port0_bit2,
		link.port0_bit1,
		link.port0_bit0,
		link.port3_bit3,
		link.port3_bit2,
		link.port3_bit1,
		link.osc_input_pin
	};

	// Two flip-flops on every pin
	generate
		for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
			localparam logic RST_BIT = 1'(`OPP_SYNC_RST >> i);
			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					sync1_r[i] <= RST_BIT;
					sync2_r[i] <= RST_BIT;
				end else begin
					sync1_r[i] <= pin_raw[i];
					sync2_r[i] <= sync1_r[i];
				end
			end
		end
	endgenerate

	wire cs_n_s = sync2_r[0];
	wire oe_n_s = sync2_r[1];
	wire [1:0] mode_s = sync2_r[3:2];
	wire vpp_s = sync2_r[4];
	wire clear_s = sync2_r[5];
	wire aclk_s = sync2_r[6];
	wire stb_n_s = sync2_r[7];
	wire [`OPP_DATA_W-1:0] bus_s = sync2_r[15:8];

	// Pin decode, only meaningful while in programming mode
	wire selected = eprom_mode_i && !cs_n_s;
	wire mode_prog = (mode_s == `OPP_MODE_PROG);
	wire mode_rd = (mode_s == `OPP_MODE_READ) || (mode_s == `OPP_MODE_VERIFY);
	wire aclk_rise = aclk_s && !aclk_prev_r;
	wire stb_fall = !stb_n_s && stb_prev_r;
	wire do_clear = eprom_mode_i && clear_s;
	wire do_step = eprom_mode_i && aclk_rise;
	wire do_write = selected && mode_prog && vpp_s && stb_fall;
	wire bad_write = selected && stb_fall && !(mode_prog && vpp_s);
	wire drive_nxt = selected && !oe_n_s && mode_rd && stb_n_s;
	wire at_top = (addr_r == ADDR_W'(DEPTH - 1));
	wire wrap_set = do_step && at_top;
	wire [15:0] wr_count_nxt = wr_count_r + 16'h0001;
	wire [`OPP_DATA_W-1:0] mem_byte = mem[addr_r];

	// Counter advance with wrap at the top location
	assign addr_nxt = at_top ? '0 : addr_r + 1'b1;

	// Previous strobe and clock levels for edges
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			aclk_prev_r <= 1'b0;
			stb_prev_r <= 1'b1;
		end else begin
			aclk_prev_r <= aclk_s;
			stb_prev_r <= stb_n_s;
		end
	end

	// Address counter
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			addr_r <= '0;
		end else if (do_clear) begin
			addr_r <= '0;
		end else if (do_step) begin
			addr_r <= addr_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wrap_r <= 1'b0;
		end else if (do_clear) begin
			wrap_r <= 1'b0;
		end else if (wrap_set) begin
			wrap_r <= 1'b1;
		end
	end

	// No reset: unwritten locations read unknown
	// Memory array, written on the strobe's falling edge
	always_ff @(posedge clk_i) begin
		if (do_write) begin
			mem[addr_r] <= bus_s;
		end
	end

	// Stored byte towards the bus
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			dout_r <= '0;
		end else begin
			dout_r <= mem_byte;
		end
	end

	// Drive enable trails the pins by the sync delay plus one register
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			drive_r <= 1'b0;
		end else begin
			drive_r <= drive_nxt;
		end
	end

	assign link.dev_data = dout_r;
	assign link.dev_data_oe = drive_r;

	// Write bookkeeping
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wr_pulse_r <= 1'b0;
			reject_r <= 1'b0;
		end else begin
			wr_pulse_r <= do_write;
			reject_r <= bad_write;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			last_wr_r <= '0;
		end else if (do_write) begin
			last_wr_r <= bus_s;
		end
	end

	// Count of accepted writes
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wr_count_r <= '0;
		end else if (do_write) begin
			wr_count_r <= wr_count_nxt;
		end
	end

	// Oscillator output has no function in programming mode
	assign osc_out_o = eprom_mode_i ? 1'b0 : osc_drive_i;
	assign addr_o = addr_r;
	assign driving_o = drive_r;
	assign wr_pulse_o = wr_pulse_r;
	assign last_wr_o = last_wr_r;
	assign wr_count_o = wr_count_r;
	assign reject_o = reject_r;
	assign wrap_o = wrap_r;
endmodule // opp_device
`default_nettype wire

// *** hdl/opp_if.sv ***
/*
 Programming pins between programmer and device.
 Assumes both ends share one clock; the data bus is resolved here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "opp_map.svh"
interface opp_if;
	logic osc_input_pin;
	logic port3_bit1;
	logic [1:0] port3_bit2;
	logic port3_bit3;
	logic port0_bit0;
	logic port0_bit1;
	logic port0_bit2;
	logic [`OPP_DATA_W-1:0] dev_data;
	logic dev_data_oe;
	logic [`OPP_DATA_W-1:0] pgm_data;
	logic pgm_data_oe;
	logic [`OPP_DATA_W-1:0] prog_data_bus;

	// Bus level from enables, pulled high when nobody drives
	assign prog_data_bus = dev_data_oe ? dev_data : (pgm_data_oe ? pgm_data : `OPP_BUS_IDLE);

	modport dev (
		input osc_input_pin,
		input port3_bit1,
		input port3_bit2,
		input port3_bit3,
		input port0_bit0,
		input port0_bit1,
		input port0_bit2,
		input prog_data_bus,
		output dev_data,
		output dev_data_oe
	);
	modport program_strobe_n (
		output osc_input_pin,
		output port3_bit1,
		output port3_bit2,
		output port3_bit3,
		output port0_bit0,
		output port0_bit1,
		output port0_bit2,
		output pgm_data,
		output pgm_data_oe,
		input prog_data_bus
	);
endinterface
`default_nettype wire

// *** hdl/opp_map.svh ***
/*
 Constants of the programming port: widths, mode codes, timing counts.
 Assumes inclusion by opp_pkg and by every file of both ends.
*/
`ifndef OPP_MAP_SVH
`define OPP_MAP_SVH
`define OPP_DATA_W 8
`define OPP_ADDR_W 8
`define OPP_MEM_DEPTH 256
`define OPP_MODE_READ 2'h0
`define OPP_MODE_PROG 2'h1
`define OPP_MODE_VERIFY 2'h2
`define OPP_CLK_NS 20
`define OPP_STEP_NS 160
`define OPP_STEP_CYC ((`OPP_STEP_NS + `OPP_CLK_NS - 1) / `OPP_CLK_NS)
`define OPP_FIFO_DEPTH 16
`define OPP_BUS_IDLE 8'hFF
`define OPP_SYNC_RST 16'h0083
`endif

// *** hdl/opp_pkg.sv ***
/*
 Types shared by both ends of the programming port.
 Assumes opp_map.svh on the include path.
*/
`include "opp_map.svh"
package opp_pkg;
	typedef logic [1:0] opp_mode_t;
	typedef logic [`OPP_DATA_W-1:0] opp_byte_t;
	typedef enum {
		OPP_IDLE,
		OPP_CLR_H,
		OPP_CLR_L,
		OPP_W_SET,
		OPP_W_STB,
		OPP_W_REL,
		OPP_R_OE,
		OPP_R_REL,
		OPP_ACK_H,
		OPP_ACK_L
	} opp_pst_e;
endpackage

// *** hdl/opp_programmer.sv ***
/*
 Programmer end: byte FIFO and pin sequencer for program and read.
 Assumes opp_if joined to a device on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "opp_map.svh"
module opp_fifo
	import opp_pkg::*;
#(
	parameter int WIDTH = `OPP_DATA_W,
	parameter int DEPTH = `OPP_FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
			$error("opp_fifo: DEPTH must be a power of two");
		end
	endgenerate
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_r;
	logic [AW:0] rp_r;
	wire empty = (wp_r == rp_r);
	wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	wire push = in_valid_i && !full;
	wire pop = out_ready_i && !empty;
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[rp_r[AW-1:0]];
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp_r[AW-1:0]] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_r + (AW+1)'(push);
			rp_r <= rp_r + (AW+1)'(pop);
		end
	end
endmodule // opp_fifo

module opp_programmer
	import opp_pkg::*;
#(
	parameter int STEP_CYC = `OPP_STEP_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	opp_if.program_strobe_n link,
	input wire logic clear_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic [`OPP_DATA_W-1:0] wr_data_i,
	input wire logic rd_req_i,
	input wire logic verify_i,
	output logic rd_valid_o,
	output logic [`OPP_DATA_W-1:0] rd_data_o,
	output logic busy_o
);
	generate
		if (STEP_CYC < 6 || STEP_CYC > 255) begin : g_chk
			$error("opp_programmer: STEP_CYC out of range");
		end
	endgenerate
	opp_pst_e st_r;
	opp_pst_e st_nxt;
	logic [7:0] tmr_r;
	logic [`OPP_DATA_W-1:0] bus1_r;
	logic [`OPP_DATA_W-1:0] bus2_r;
	logic [`OPP_DATA_W-1:0] wbyte_r;
	logic [`OPP_DATA_W-1:0] rd_data_r;
	logic rd_valid_r;
	opp_mode_t mode_r;
	logic f_valid;
	logic [`OPP_DATA_W-1:0] f_data;

	wire idle = (st_r == OPP_IDLE);
	wire step_done = (tmr_r == 8'h00);
	wire take_byte = idle && !clear_i && f_valid;
	wire take_rd = idle && !clear_i && !f_valid && rd_req_i;

	opp_fifo #(.WIDTH(`OPP_DATA_W), .DEPTH(`OPP_FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.in_valid_i(wr_valid_i),
		.in_ready_o(wr_ready_o),
		.in_data_i(wr_data_i),
		.out_valid_o(f_valid),
		.out_ready_i(take_byte),
		.out_data_o(f_data)
	);

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			OPP_IDLE: begin
				if (clear_i) st_nxt = OPP_CLR_H;
				else if (f_valid) st_nxt = OPP_W_SET;
				else if (rd_req_i) st_nxt = OPP_R_OE;
			end
			OPP_CLR_H: if (step_done) st_nxt = OPP_CLR_L;
			OPP_CLR_L: if (step_done) st_nxt = OPP_IDLE;
			OPP_W_SET: if (step_done) st_nxt = OPP_W_STB;
			OPP_W_STB: if (step_done) st_nxt = OPP_W_REL;
			OPP_W_REL: if (step_done) st_nxt = OPP_ACK_H;
			OPP_R_OE: if (step_done) st_nxt = OPP_R_REL;
			OPP_R_REL: if (step_done) st_nxt = OPP_ACK_H;
			OPP_ACK_H: if (step_done) st_nxt = OPP_ACK_L;
			OPP_ACK_L: if (step_done) st_nxt = OPP_IDLE;
			default: st_nxt = OPP_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_r <= OPP_IDLE;
			tmr_r <= 8'h00;
		end else begin
			st_r <= st_nxt;
			tmr_r <= (st_nxt != st_r) ? 8'(STEP_CYC - 1) : (step_done ? 8'h00 : tmr_r - 8'h01);
		end
	end

	// Bus seen by the programmer passes two flip-flops
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			bus1_r <= '0;
			bus2_r <= '0;
		end else begin
			bus1_r <= link.prog_data_bus;
			bus2_r <= bus1_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wbyte_r <= '0;
			mode_r <= `OPP_MODE_READ;
			rd_data_r <= '0;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= (st_r == OPP_R_OE) && step_done;
			if (take_byte) begin
				wbyte_r <= f_data;
				mode_r <= `OPP_MODE_PROG;
			end else if (take_rd) begin
				mode_r <= verify_i ? `OPP_MODE_VERIFY : `OPP_MODE_READ;
			end
			if ((st_r == OPP_R_OE) && step_done) begin
				rd_data_r <= bus2_r;
			end
		end
	end

	// Pin levels per step
	assign link.osc_input_pin = !(st_r inside {OPP_W_SET, OPP_W_STB, OPP_W_REL, OPP_R_OE, OPP_R_REL});
	assign link.port3_bit1 = (st_r != OPP_R_OE);
	assign link.port3_bit2 = mode_r;
	assign link.port3_bit3 = (st_r inside {OPP_W_SET, OPP_W_STB, OPP_W_REL});
	assign link.port0_bit0 = (st_r == OPP_CLR_H);
	assign link.port0_bit1 = (st_r == OPP_ACK_H);
	assign link.port0_bit2 = (st_r != OPP_W_STB);
	assign link.pgm_data = wbyte_r;
	assign link.pgm_data_oe = (st_r inside {OPP_W_SET, OPP_W_STB, OPP_W_REL});
	assign rd_valid_o = rd_valid_r;
	assign rd_data_o = rd_data_r;
	assign busy_o = !idle;
endmodule // opp_programmer
`default_nettype wire

// *** sim/opp_link_asserts.sv ***
/*
 Checker on the programming pins between the two ends.
 Assumes one clock for both ends and the bench's reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "opp_map.svh"
module opp_link_asserts (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic osc_input_pin,
	input wire logic port3_bit1,
	input wire logic [1:0] port3_bit2,
	input wire logic port3_bit3,
	input wire logic port0_bit2,
	input wire logic [`OPP_DATA_W-1:0] dev_data,
	input wire logic dev_data_oe,
	input wire logic pgm_data_oe,
	input wire logic [`OPP_DATA_W-1:0] prog_data_bus
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	property p_bus_dev; $rose(dev_data_oe) |-> !$past(port3_bit1, 2) && !$past(osc_input_pin, 2); endproperty
	a_bus_dev: assert property (p_bus_dev) else $error("device drove without select and output enable");
	property p_one_drv; !(dev_data_oe && pgm_data_oe); endproperty
	a_one_drv: assert property (p_one_drv) else $error("both ends drive the bus");
	property p_oe_rel; port3_bit1 [*5] |-> !dev_data_oe; endproperty
	a_oe_rel: assert property (p_oe_rel) else $error("device drives with output enable high");
	property p_cs_rel; osc_input_pin [*5] |-> !dev_data_oe; endproperty
	a_cs_rel: assert property (p_cs_rel) else $error("device drives while deselected");
	property p_prog_rel; (port3_bit2 == `OPP_MODE_PROG) [*5] |-> !dev_data_oe; endproperty
	a_prog_rel: assert property (p_prog_rel) else $error("device drives in program mode");
	property p_drive;
		$fell(port3_bit1) && !osc_input_pin && port3_bit2 != `OPP_MODE_PROG && port0_bit2 |-> ##[1:6] dev_data_oe;
	endproperty
	a_drive: assert property (p_drive) else $error("device missed a read");
	property p_oe_tog; $fell(port3_bit1) |-> ##[1:12] port3_bit1; endproperty
	a_oe_tog: assert property (p_oe_tog) else $error("output enable held low");
	property p_strobe; !port0_bit2 |-> pgm_data_oe && !osc_input_pin && port3_bit3 && port3_bit1; endproperty
	a_strobe: assert property (p_strobe) else $error("strobe without selected write data");
	c_write: cover property ($fell(port0_bit2));
	c_drive: cover property ($rose(dev_data_oe));
	c_verify: cover property (dev_data_oe && port3_bit2 == `OPP_MODE_VERIFY);
endmodule // opp_link_asserts
`default_nettype wire

// *** sim/otp_program_port_bench.sv ***
/*
 Bench joining programmer and device over the pins.
 Assumes the design files and opp_map.svh on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "opp_map.svh"
module otp_program_port_bench
	import opp_pkg::*;
;
	logic clk_i = 0, nrst_i = 0, eprom_mode_i = 1, osc_drive_i = 0, clear_i = 0;
	logic wr_valid_i = 0, rd_req_i = 0, verify_i = 0;
	logic [7:0] wr_data_i = 8'h00;
	logic osc_out_o, driving_o, wr_pulse_o, reject_o, wrap_o, wr_ready_o, rd_valid_o, busy_o;
	logic [7:0] addr_o, last_wr_o, rd_data_o;
	logic [15:0] wr_count_o, pulses = 0, rdv = 0, rej = 0, refused = 0, drv = 0;
	logic [7:0] mem [0:19];
	logic [31:0] seed_r = 32'h00015219;
	int fails = 0, checks_done = 0, n;

	opp_if link ();
	opp_device #(.ADDR_W(8), .DEPTH(256)) i_opp_device (.clk_i(clk_i), .nrst_i(nrst_i), .link(link.dev),
		.eprom_mode_i(eprom_mode_i), .osc_drive_i(osc_drive_i), .osc_out_o(osc_out_o), .addr_o(addr_o),
		.driving_o(driving_o), .wr_pulse_o(wr_pulse_o), .last_wr_o(last_wr_o), .wr_count_o(wr_count_o),
		.reject_o(reject_o), .wrap_o(wrap_o));
	opp_programmer #(.STEP_CYC(6)) i_opp_programmer (.clk_i(clk_i), .nrst_i(nrst_i), .link(link.program_strobe_n),
		.clear_i(clear_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .wr_data_i(wr_data_i),
		.rd_req_i(rd_req_i), .verify_i(verify_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .busy_o(busy_o));
	opp_link_asserts i_opp_link_asserts (.clk_i(clk_i), .nrst_i(nrst_i), .osc_input_pin(link.osc_input_pin),
		.port3_bit1(link.port3_bit1), .port3_bit2(link.port3_bit2), .port3_bit3(link.port3_bit3),
		.port0_bit2(link.port0_bit2), .dev_data(link.dev_data), .dev_data_oe(link.dev_data_oe),
		.pgm_data_oe(link.pgm_data_oe), .prog_data_bus(link.prog_data_bus));

	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (wr_pulse_o === 1'b1) pulses++;
		if (rd_valid_o === 1'b1) rdv++;
		if (reject_o === 1'b1) rej++;
		if (driving_o === 1'b1) drv++;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (fails == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic idle;
		int q;
		q = 0;
		repeat (4000) begin
			@(negedge clk_i);
			q = (busy_o === 1'b0) ? q + 1 : 0;
			if (q == 6) break;
		end
	endtask
	// Level request held until taken, then idle
	task automatic req(input logic clr, input logic vfy);
		@(negedge clk_i);
		clear_i = clr;
		rd_req_i = !clr;
		verify_i = vfy;
		repeat (20) if (busy_o !== 1'b1) @(negedge clk_i);
		clear_i = 0;
		rd_req_i = 0;
		idle;
	endtask

	initial begin
		#600000;
		fails++;
		tally_and_finish;
	end
	initial begin
		repeat (8) @(negedge clk_i);
		nrst_i = 1;
		chk(osc_out_o, 0);
		req(1, 0);
		chk(addr_o, 0);
		for (n = 0; n < 20; n++) begin
			seed_r = lfsr(seed_r);
			mem[n] = (n == 0) ? 8'h00 : (n == 1) ? 8'hFF : seed_r[7:0];
		end
		n = 0;
		while (n < 20) begin
			@(negedge clk_i);
			wr_valid_i = 1;
			wr_data_i = mem[n];
			@(posedge clk_i);
			if (wr_ready_o === 1'b1) n++;
			else refused++;
		end
		@(negedge clk_i);
		wr_valid_i = 0;
		idle;
		chk(refused != 0, 1);
		chk(wr_count_o, 20);
		chk(pulses, 20);
		chk(last_wr_o, mem[19]);
		chk(addr_o, 20);
		req(1, 0);
		for (n = 0; n < 258; n++) begin
			req(0, n[0]);
			if (n % 256 < 20) chk(rd_data_o, mem[n % 256]);
		end
		chk(rdv, 258);
		chk(wrap_o, 1);
		chk(addr_o, 2);
		chk(rej, 0);
		chk(drv, 258 * 6);
		req(1, 0);
		chk(wrap_o, 0);
		chk(addr_o, 0);
		chk(driving_o, 0);
		@(negedge clk_i);
		eprom_mode_i = 0;
		osc_drive_i = ~seed_r[8];
		@(negedge clk_i);
		chk(osc_out_o, {15'h0000, ~seed_r[8]});
		tally_and_finish;
	end
endmodule // otp_program_port_bench
`default_nettype wire
